// ==== src/cmob_pkg.sv ====
package cmob_pkg;

  // ************************************************************
  // register map
  // ************************************************************
  localparam logic [7:0] ADDR_PAGE   = 8'h00; // selects object for control/status
  localparam logic [7:0] ADDR_CTRL   = 8'h01; // object_control_reg of selected object
  localparam logic [7:0] ADDR_STAT   = 8'h02; // object_status_reg of selected object
  localparam logic [7:0] ADDR_EN_LO  = 8'h03; // object_enable_regs, objects 0..7
  localparam logic [7:0] ADDR_EN_HI  = 8'h04; // object_enable_regs, objects 8..14
  localparam logic [7:0] ADDR_GIT    = 8'h05; // general_interrupt_reg
  localparam logic [7:0] ADDR_GIE    = 8'h06; // interrupt enables

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int CTRL_TYPE_LSB = 6;   // object_type_field in ctrl bits 7:6
  localparam int STAT_RXOK_BIT = 5;   // receive-complete in status
  localparam int STAT_TXOK_BIT = 6;   // transmit-complete in status
  localparam int GIT_BUF_BIT   = 4;   // buffer_full_flag in general_interrupt_reg
  localparam int GIE_BUF_BIT   = 1;   // buffer_full_int_enable
  localparam int GIE_CAN_BIT   = 7;   // general CAN interrupt enable

  // ************************************************************
  // reset values and types
  // ************************************************************
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam int         NUM_OBJ  = 15;

  typedef enum logic [1:0] {
    CMOB_DISABLED,
    CMOB_TX,
    CMOB_RX,
    CMOB_RX_BUF
  } cmob_type_e;

endpackage : cmob_pkg

// ==== src/cmob_buffer.sv ====
// Overview of operation
// RULE1: two-bit type: off, tx, rx, buffer-rx
// RULE2: configuring an object sets its enable bit
// RULE3: finished transfer clears the enable bit
// RULE4: software rewrites type to reactivate object
// RULE5: object types may sit at any number
// RULE6: buffer is any subset, up to 15
// RULE7: software sets type 11 on buffer objects
// RULE8: software programs identical filters on buffer objects
// RULE9: open mask accepts every frame into buffer
// RULE10: frame goes to lowest free buffer object
// RULE11: storing a frame sets receive-complete flag
// RULE12: software clears flag and re-enables object
// RULE13: full buffer sets flag, may interrupt
// RULE14: full buffer discards frames, status untouched
// RULE15: flag stays set until software clears it
// RULE16: both enables needed for buffer interrupt
// RULE17: full means no buffer object still enabled
//
// The register offsets and the plain strobed port were left to the implementer.
module cmob_buffer
#(
  parameter int N_OBJ = cmob_pkg::NUM_OBJ
) (
  input  wire logic       ref_clk,
  input  wire logic       srst,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic       rx_frame_done,
  input  wire logic       rx_buf_hit,
  input  wire logic [3:0] rx_hit_obj,
  input  wire logic       tx_frame_done,
  input  wire logic [3:0] tx_done_obj,
  output logic      [3:0] store_obj,
  output logic            store_stb,
  output logic            buf_full,
  output logic            can_irq
);
  import cmob_pkg::*;

  // ************************************************************
  // state
  // ************************************************************
  logic [1:0]       type_r [N_OBJ];
  logic [N_OBJ-1:0] active_r;
  logic [N_OBJ-1:0] rxok_r;
  logic [N_OBJ-1:0] txok_r;
  logic [3:0]       page_r;
  logic             bfull_flag_r;
  logic             gie_buf_r;
  logic             gie_can_r;
  logic [N_OBJ-1:0] buf_free;
  logic             free_any;
  logic [3:0]       low_free;
  logic             take_frame;
  logic             ctrl_wr;
  logic             stat_wr;
  logic             buf_reenable;
  logic [1:0]       wr_type;

  // object-page accesses; pages past the last object are ignored
  assign wr_type = reg_wdata[CTRL_TYPE_LSB +: 2];
  assign ctrl_wr = reg_wr && (reg_addr == ADDR_CTRL) && (page_r < 4'(N_OBJ));
  assign stat_wr = reg_wr && (reg_addr == ADDR_STAT) && (page_r < 4'(N_OBJ));

  // free buffer objects: type 11 and still enabled
  generate
    for (genvar i = 0; i < N_OBJ; i++) begin : g_free
      assign buf_free[i] = (type_r[i] == 2'(CMOB_RX_BUF)) && active_r[i]; // RULE6 RULE5
    end
  endgenerate

  // lowest free object wins
  always_comb begin
    low_free = 4'h0;
    free_any = 1'b0;
    for (int i = N_OBJ - 1; i >= 0; i--) begin
      if (buf_free[i]) begin
        low_free = 4'(i); // RULE10
        free_any = 1'b1;
      end
    end
  end

  // filter result arrives on rx_buf_hit; open mask means every frame hits
  assign take_frame   = rx_frame_done && rx_buf_hit && free_any; // RULE9 RULE14
  assign buf_full     = !free_any; // RULE17
  assign buf_reenable = ctrl_wr && (wr_type == 2'(CMOB_RX_BUF));

  // ************************************************************
  // per-object type and enable
  // ************************************************************
  // type field of each object, written through the page pointer
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      for (int i = 0; i < N_OBJ; i++) begin
        type_r[i] <= 2'(CMOB_DISABLED);
      end
    end else if (ctrl_wr) begin
      type_r[page_r] <= reg_wdata[CTRL_TYPE_LSB +: 2]; // RULE1
    end
  end

  // enable set on config, cleared on completion; rewrite wins
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      active_r <= '0;
    end else begin
      for (int i = 0; i < N_OBJ; i++) begin
        if (take_frame && low_free == 4'(i)) begin
          active_r[i] <= 1'b0; // RULE3
        end
        if (tx_frame_done && tx_done_obj == 4'(i) && type_r[i] == 2'(CMOB_TX)) begin
          active_r[i] <= 1'b0; // RULE3
        end
        if (rx_frame_done && !rx_buf_hit && rx_hit_obj == 4'(i) && type_r[i] == 2'(CMOB_RX)) begin
          active_r[i] <= 1'b0; // RULE3
        end
        if (ctrl_wr && page_r == 4'(i)) begin
          active_r[i] <= (reg_wdata[CTRL_TYPE_LSB +: 2] != 2'(CMOB_DISABLED)); // RULE2
        end
      end
    end
  end

  // ************************************************************
  // completion flags, set wins over software clear
  // ************************************************************
  // receive and transmit complete flags per object
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rxok_r <= '0;
      txok_r <= '0;
    end else begin
      for (int i = 0; i < N_OBJ; i++) begin
        if (stat_wr && page_r == 4'(i)) begin
          rxok_r[i] <= reg_wdata[STAT_RXOK_BIT];
          txok_r[i] <= reg_wdata[STAT_TXOK_BIT];
        end
        if ((take_frame && low_free == 4'(i)) ||
            (rx_frame_done && !rx_buf_hit && rx_hit_obj == 4'(i) && type_r[i] == 2'(CMOB_RX) && active_r[i])) begin
          rxok_r[i] <= 1'b1; // RULE11
        end
        if (tx_frame_done && tx_done_obj == 4'(i) && type_r[i] == 2'(CMOB_TX) && active_r[i]) begin
          txok_r[i] <= 1'b1;
        end
      end
    end
  end

  // store strobe toward the mailbox memory
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      store_stb <= 1'b0;
      store_obj <= 4'h0;
    end else begin
      store_stb <= take_frame; // RULE14
      if (take_frame) begin
        store_obj <= low_free; // RULE10
      end
    end
  end

  // ************************************************************
  // buffer-full flag and interrupt
  // ************************************************************
  // sticky full flag, raised when the last free object is taken
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      bfull_flag_r <= 1'b0;
    end else if (take_frame && buf_free == (N_OBJ'(1) << low_free)) begin
      bfull_flag_r <= 1'b1; // RULE13
    end else if (reg_wr && reg_addr == ADDR_GIT && !reg_wdata[GIT_BUF_BIT]) begin
      bfull_flag_r <= 1'b0; // RULE15
    end
  end

  // interrupt enables and object page pointer
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      gie_buf_r <= 1'b0;
      gie_can_r <= 1'b0;
      page_r    <= 4'h0;
    end else if (reg_wr) begin
      if (reg_addr == ADDR_GIE) begin
        gie_buf_r <= reg_wdata[GIE_BUF_BIT];
        gie_can_r <= reg_wdata[GIE_CAN_BIT];
      end
      if (reg_addr == ADDR_PAGE) begin
        page_r <= reg_wdata[7:4];
      end
    end
  end

  // interrupt request, one cycle behind the flag
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      can_irq <= 1'b0;
    end else begin
      can_irq <= bfull_flag_r && gie_buf_r && gie_can_r; // RULE13
    end
  end

  // ************************************************************
  // read port, data one cycle after strobe
  // ************************************************************
  // read mux, zero whenever no read is pending
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      reg_rdata <= RST_BYTE;
    end else if (reg_rd) begin
      reg_rdata <= RST_BYTE;
      case (reg_addr)
        ADDR_PAGE:  reg_rdata <= {page_r, 4'h0};
        ADDR_CTRL:  if (page_r < 4'(N_OBJ)) reg_rdata <= {type_r[page_r], 6'h00};
        ADDR_STAT:  if (page_r < 4'(N_OBJ)) reg_rdata <= {1'b0, txok_r[page_r], rxok_r[page_r], 5'h00};
        ADDR_EN_LO: reg_rdata <= active_r[7:0];
        ADDR_EN_HI: reg_rdata <= {1'b0, active_r[N_OBJ-1:8]};
        ADDR_GIT:   reg_rdata <= {3'h0, bfull_flag_r, 4'h0};
        ADDR_GIE:   reg_rdata <= {gie_can_r, 5'h00, gie_buf_r, 1'b0};
        default:    reg_rdata <= RST_BYTE;
      endcase
    end else begin
      reg_rdata <= RST_BYTE;
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  // a non-disabled type turns the object on
  property p_cfg_sets_en;
    @(posedge ref_clk) disable iff (srst)
      ctrl_wr && wr_type != 2'(CMOB_DISABLED) |=> active_r[$past(page_r)];
  endproperty
  a_cfg_sets_en: assert property (p_cfg_sets_en) else $error("config did not set enable"); // RULE2

  // the written type is kept per object
  property p_type_stored;
    @(posedge ref_clk) disable iff (srst)
      ctrl_wr |=> type_r[$past(page_r)] == $past(wr_type);
  endproperty
  a_type_stored: assert property (p_type_stored) else $error("type field not stored"); // RULE1

  // type zero turns the object off
  property p_cfg_disables;
    @(posedge ref_clk) disable iff (srst)
      ctrl_wr && wr_type == 2'(CMOB_DISABLED) |=> !active_r[$past(page_r)];
  endproperty
  a_cfg_disables: assert property (p_cfg_disables) else $error("disable left object on"); // RULE1

  // a stored frame retires its buffer object
  property p_store_clears_en;
    @(posedge ref_clk) disable iff (srst)
      take_frame && !ctrl_wr |=> !active_r[$past(low_free)] && rxok_r[$past(low_free)];
  endproperty
  a_store_clears_en: assert property (p_store_clears_en) else $error("store did not retire object"); // RULE3

  // a finished transmission retires the object and flags it
  property p_tx_retires;
    @(posedge ref_clk) disable iff (srst)
      tx_frame_done && tx_done_obj < 4'(N_OBJ) && !ctrl_wr &&
      type_r[tx_done_obj] == 2'(CMOB_TX) && active_r[tx_done_obj]
      |=> !active_r[$past(tx_done_obj)] && txok_r[$past(tx_done_obj)];
  endproperty
  a_tx_retires: assert property (p_tx_retires) else $error("transmit did not retire object"); // RULE3

  // a plain reception retires its receive object
  property p_rx_retires;
    @(posedge ref_clk) disable iff (srst)
      rx_frame_done && !rx_buf_hit && rx_hit_obj < 4'(N_OBJ) && !ctrl_wr &&
      type_r[rx_hit_obj] == 2'(CMOB_RX) && active_r[rx_hit_obj]
      |=> !active_r[$past(rx_hit_obj)] && rxok_r[$past(rx_hit_obj)];
  endproperty
  a_rx_retires: assert property (p_rx_retires) else $error("receive did not retire object"); // RULE3

  // with room left, every matching frame is stored
  property p_open_mask;
    @(posedge ref_clk) disable iff (srst)
      rx_frame_done && rx_buf_hit && !buf_full |=> store_stb;
  endproperty
  a_open_mask: assert property (p_open_mask) else $error("matching frame not stored"); // RULE9

  // the strobe names the chosen object
  property p_store_obj;
    @(posedge ref_clk) disable iff (srst)
      take_frame |=> store_stb && store_obj == $past(low_free);
  endproperty
  a_store_obj: assert property (p_store_obj) else $error("wrong store object"); // RULE10

  // no free object below the chosen one
  property p_lowest;
    @(posedge ref_clk) disable iff (srst)
      take_frame |-> (buf_free & ((N_OBJ'(1) << low_free) - N_OBJ'(1))) == '0;
  endproperty
  a_lowest: assert property (p_lowest) else $error("not lowest free object"); // RULE10

  // storing marks the object readable
  property p_rxok_set;
    @(posedge ref_clk) disable iff (srst)
      take_frame |=> rxok_r[$past(low_free)];
  endproperty
  a_rxok_set: assert property (p_rxok_set) else $error("receive-complete not set"); // RULE11

  // no strobe while full
  property p_full_discard;
    @(posedge ref_clk) disable iff (srst)
      buf_full && rx_frame_done |=> !store_stb;
  endproperty
  a_full_discard: assert property (p_full_discard) else $error("frame stored while full"); // RULE14

  // a discarded frame leaves status and enables alone
  property p_full_untouched;
    @(posedge ref_clk) disable iff (srst)
      rx_frame_done && rx_buf_hit && buf_full && !stat_wr && !ctrl_wr && !tx_frame_done
      |=> rxok_r == $past(rxok_r) && active_r == $past(active_r);
  endproperty
  a_full_untouched: assert property (p_full_untouched) else $error("status changed while full"); // RULE14

  // taking the last free object raises the flag
  property p_fill_flag;
    @(posedge ref_clk) disable iff (srst)
      take_frame && !ctrl_wr ##1 buf_full |-> bfull_flag_r;
  endproperty
  a_fill_flag: assert property (p_fill_flag) else $error("full flag not raised"); // RULE13

  // only software drops the flag
  property p_flag_sticky;
    @(posedge ref_clk) disable iff (srst)
      bfull_flag_r && !(reg_wr && reg_addr == ADDR_GIT) |=> bfull_flag_r;
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("full flag dropped"); // RULE15

  // flag with both enables requests an interrupt
  property p_irq;
    @(posedge ref_clk) disable iff (srst)
      bfull_flag_r && gie_buf_r && gie_can_r |=> can_irq;
  endproperty
  a_irq: assert property (p_irq) else $error("missing buffer interrupt"); // RULE13

  // no request without flag and both enables
  property p_irq_off;
    @(posedge ref_clk) disable iff (srst)
      !(bfull_flag_r && gie_buf_r && gie_can_r) |=> !can_irq;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("spurious buffer interrupt"); // RULE13

  // re-enabling a buffer object ends the full state
  property p_reenable;
    @(posedge ref_clk) disable iff (srst)
      buf_reenable |=> !buf_full;
  endproperty
  a_reenable: assert property (p_reenable) else $error("re-enable left buffer full"); // RULE17

endmodule : cmob_buffer

// ==== verification/cmob_can_node.sv ====
module cmob_can_node (
  input  wire logic       ref_clk,
  output logic            rx_frame_done,
  output logic            rx_buf_hit,
  output logic      [3:0] rx_hit_obj,
  output logic            tx_frame_done,
  output logic      [3:0] tx_done_obj
);
  timeunit 1ns;
  timeprecision 100ps;
  // ****
  // far-side node: completed frames
  // ****
  logic       rx_r = 1'b0;
  logic       tx_r = 1'b0;
  logic       hit_r = 1'b0;
  logic [3:0] obj_r = 4'h0;
  logic [3:0] noise_r = 4'h0;
  // unqualified lines carry a changing pattern
  always @(posedge ref_clk) noise_r <= noise_r + 4'h5;
  assign rx_frame_done = rx_r;
  assign tx_frame_done = tx_r;
  assign rx_buf_hit    = rx_r ? hit_r : noise_r[0];
  assign rx_hit_obj    = rx_r ? obj_r : noise_r;
  assign tx_done_obj   = tx_r ? obj_r : ~noise_r;
  // one finished frame, pulse held for one clock
  task automatic send(input logic is_tx, input logic hit, input logic [3:0] obj);
    @(posedge ref_clk);
    rx_r  <= ~is_tx;
    tx_r  <= is_tx;
    hit_r <= hit;
    obj_r <= obj;
    @(posedge ref_clk);
    rx_r  <= 1'b0;
    tx_r  <= 1'b0;
  endtask : send
endmodule : cmob_can_node

// ==== verification/test_can_message_object_buffer.sv ====
module test_can_message_object_buffer;
  timeunit 1ns;
  timeprecision 100ps;
  import cmob_pkg::*;
  // ****
  // signals and instances
  // ****
  logic       ref_clk = 1'b0, srst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic       rx_frame_done, rx_buf_hit, tx_frame_done, store_stb, buf_full, can_irq;
  logic [3:0] rx_hit_obj, tx_done_obj, store_obj;
  int         error_cnt = 0, check_count = 0;
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin error_cnt++; $display("mismatch at %0t: got %h want %h", $time, g, e); end end
  always #2.5 ref_clk = ~ref_clk;
  cmob_buffer cmob_buffer_i (.ref_clk, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .rx_frame_done, .rx_buf_hit, .rx_hit_obj, .tx_frame_done, .tx_done_obj, .store_obj, .store_stb,
    .buf_full, .can_irq);
  cmob_can_node cmob_can_node_i (.ref_clk, .rx_frame_done, .rx_buf_hit, .rx_hit_obj, .tx_frame_done,
    .tx_done_obj);
  // ****
  // bus and frame helpers
  // ****
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr    <= 1'b0;
    #1;
  endtask : wr
  // read, mask and compare the data of the following cycle
  task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd   <= 1'b0;
    #1;
    `CHK(reg_rdata & m, e)
  endtask : rd
  task automatic cfg(input logic [3:0] o, input logic [1:0] t);
    wr(ADDR_PAGE, {o, 4'h0});
    wr(ADDR_CTRL, {t, 6'h00});
  endtask : cfg
  task automatic frm(input logic hit, input logic [3:0] o, input logic stb, input logic [3:0] so);
    cmob_can_node_i.send(1'b0, hit, o);
    #1;
    `CHK(store_stb, stb)
    if (stb) `CHK(store_obj, so)
  endtask : frm
  // ****
  // scenarios
  // ****
  task automatic t_reset();
    rd(ADDR_EN_LO, 8'hFF, 8'h00);
    rd(8'h07, 8'hFF, 8'h00);
    `CHK(buf_full, 1'b1)
    `CHK(can_irq, 1'b0)
  endtask : t_reset
  task automatic t_config();
    cfg(4'h0, CMOB_DISABLED);
    cfg(4'h1, CMOB_TX);
    cfg(4'h5, CMOB_RX);
    cfg(4'h3, CMOB_RX_BUF);
    cfg(4'h9, CMOB_RX_BUF);
    rd(ADDR_CTRL, 8'hC0, 8'hC0);
    wr(ADDR_PAGE, 8'hF0);
    wr(ADDR_CTRL, 8'hC0);
    rd(ADDR_CTRL, 8'hFF, 8'h00);
    rd(ADDR_EN_LO, 8'hFF, 8'h2A);
    rd(ADDR_EN_HI, 8'hFF, 8'h02);
    `CHK(buf_full, 1'b0)
  endtask : t_config
  task automatic t_done();
    cmob_can_node_i.send(1'b1, 1'b0, 4'h1);
    cmob_can_node_i.send(1'b0, 1'b0, 4'h5);
    #1;
    `CHK(store_stb, 1'b0)
    wr(ADDR_PAGE, 8'h10);
    rd(ADDR_STAT, 8'h40, 8'h40);
    rd(ADDR_EN_LO, 8'hFF, 8'h08);
    cfg(4'h1, CMOB_TX);
    rd(ADDR_EN_LO, 8'hFF, 8'h0A);
  endtask : t_done
  task automatic t_fill();
    wr(ADDR_GIE, 8'h82);
    rd(ADDR_GIE, 8'hFF, 8'h82);
    frm(1'b1, 4'hE, 1'b1, 4'h3);
    `CHK(buf_full, 1'b0)
    wr(ADDR_PAGE, 8'h30);
    rd(ADDR_STAT, 8'h20, 8'h20);
    frm(1'b1, 4'h0, 1'b1, 4'h9);
    `CHK(buf_full, 1'b1)
    @(posedge ref_clk);
    #1;
    `CHK(can_irq, 1'b1)
    rd(ADDR_GIT, 8'h10, 8'h10);
    wr(ADDR_GIE, 8'h02);
    @(posedge ref_clk);
    #1;
    `CHK(can_irq, 1'b0)
    wr(ADDR_GIE, 8'h82);
  endtask : t_fill
  task automatic t_full();
    wr(ADDR_PAGE, 8'h90);
    wr(ADDR_STAT, 8'h00);
    frm(1'b1, 4'h0, 1'b0, 4'h0);
    rd(ADDR_STAT, 8'h20, 8'h00);
    rd(ADDR_GIT, 8'h10, 8'h10);
    wr(ADDR_GIT, 8'h00);
    rd(ADDR_GIT, 8'h10, 8'h00);
    `CHK(can_irq, 1'b0)
    wr(ADDR_CTRL, 8'hC0);
    wr(ADDR_PAGE, 8'h30);
    wr(ADDR_STAT, 8'h00);
    wr(ADDR_CTRL, 8'hC0);
    `CHK(buf_full, 1'b0)
    frm(1'b1, 4'h0, 1'b1, 4'h3);
    frm(1'b1, 4'h0, 1'b1, 4'h9);
    `CHK(buf_full, 1'b1)
  endtask : t_full
  // reset in mid-run clears enables, flag and request
  task automatic t_rerst();
    @(posedge ref_clk);
    srst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    srst <= 1'b0;
    rd(ADDR_EN_LO, 8'hFF, 8'h00);
    rd(ADDR_GIT, 8'h10, 8'h00);
    `CHK(buf_full, 1'b1)
    `CHK(can_irq, 1'b0)
  endtask : t_rerst
  // ****
  // verdict, watchdog and main sequence
  // ****
  task automatic summarize();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : summarize
  // cut a hang short
  initial begin
    repeat (4000) @(posedge ref_clk);
    error_cnt++;
    summarize();
  end
  // reset, then every scenario in turn
  initial begin
    repeat (20) @(posedge ref_clk);
    srst <= 1'b0;
    t_reset();
    t_config();
    t_done();
    t_fill();
    t_full();
    t_rerst();
    summarize();
  end
endmodule : test_can_message_object_buffer
